// ===== logic/twi_flags.sv
`timescale 1ns/10ps
// Behaviour
// - reserved status bits 7:5 always read zero
// - set ack fail flag on unacknowledged byte
// - irq on flags 4:1 only when enabled
// - read or disable clears flags 4:1
// - error flags never stretch the clock line
// - slave stop after ack sets stop flag
// - set arbitration lost flag on lost arbitration
// - arbitration loss returns to slave mode
// - no arbitration during master receiver ack bit
// - misplaced start or stop sets bus fault
// - slave general call with enable sets flag
// - general call cleared by stop or disable
// - clock control bit7 selects fast, survives disable
// - divider bits 6:0 set rate, survive disable
// - hold clock low while byte done set
`include "twi_flags_regs.svh"

module twi_flags
    import twi_flags_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // byte transfer engine
    input wire bus_event_t bus_event,
    input wire bus_context_t bus_context,
    // bus clock pin, open drain
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    // status toward the engine and the cpu
    output logic master_mode_flag,
    output logic fast_mode_select,
    output logic irq
);

    // half period of the bus clock for a mode and divider
    function automatic logic [15:0] half_cycles(input logic fast, input logic [6:0] div);
        logic [15:0] d;
        d = {9'h000, div};
        if (fast)
            half_cycles = 16'(`SCL_FAST_BASE + d * `SCL_FAST_STEP);
        else
            half_cycles = 16'(`SCL_STD_BASE + d * `SCL_STD_STEP);
    endfunction

    // register state
    logic [7:0] ctrl_reg, ctrl_next;         // irq, general call, interface enables
    logic [4:0] status2_reg, status2_next;   // error and general call flags
    logic [7:0] clkctl_reg, clkctl_next;     // mode bit and divider
    logic master_reg, master_next;           // master mode indication
    logic pready_reg;                        // access phase answer
    logic [31:0] prdata_reg;                 // captured read data
    logic pslverr_reg;                       // unmapped address answer
    logic irq_reg;                           // interrupt request
    scl_state_t scl_state_reg, scl_state_next;
    logic [15:0] scl_cnt_reg, scl_cnt_next;  // half period counter
    logic scl_oe_reg, scl_oe_next;           // drive clock line low

    // control bit views
    wire logic irq_enable = ctrl_reg[`CTRL_IRQ_EN_BIT];
    wire logic general_call_enable = ctrl_reg[`CTRL_GC_EN_BIT];
    wire logic interface_enable = ctrl_reg[`CTRL_IF_EN_BIT];
    wire logic [6:0] clock_divider = clkctl_reg[6:0];

    // apb decode
    wire logic setup_seen = psel & ~penable;
    wire logic access = psel & penable & pready_reg;
    wire logic wr = access & pwrite;
    wire logic rd = access & ~pwrite;
    wire logic hit_ctrl = paddr == ADDR_W'(`OFS_CTRL);
    wire logic hit_status2 = paddr == ADDR_W'(`OFS_STATUS2);
    wire logic hit_clkctl = paddr == ADDR_W'(`OFS_CLKCTL);
    wire logic hit_state = paddr == ADDR_W'(`OFS_STATE);
    wire logic hit_any = hit_ctrl | hit_status2 | hit_clkctl | hit_state;

    // status2 read completing: clears only bits that were returned
    wire logic status2_rd = rd & hit_status2;
    wire logic [4:0] read_clear = status2_rd ?
        (prdata_reg[4:0] & `ST_READ_CLEAR_MASK) : 5'h00;

    // qualified hardware set events
    wire logic arb_lost_ev = bus_event.arb_lost & ~bus_context.rx_ack_phase;
    wire logic stop_seen_set = bus_event.stop_cond & ~master_reg
        & bus_context.ack_enable & bus_context.acked_last;
    wire logic gc_set = bus_event.gc_addr & ~master_reg & general_call_enable;

    // set vector in flag order
    wire logic [4:0] flag_set = {
        bus_event.nack,
        stop_seen_set,
        arb_lost_ev,
        bus_event.misplaced,
        gc_set
    };

    // read data selection; reserved bits stay zero
    wire logic [31:0] rd_value =
        hit_ctrl ? {24'h000000, ctrl_reg} :
        hit_status2 ? {27'h0000000, status2_reg} :
        hit_clkctl ? {24'h000000, clkctl_reg} :
        hit_state ? {29'h00000000, scl_in, scl_oe_reg, master_reg} :
        32'h00000000;

    // control register write
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (wr && hit_ctrl)
        begin
            ctrl_next = pwdata[7:0] & `CTRL_MASK;
        end
    end

    // clock control write, no clear on disable
    always_comb
    begin
        clkctl_next = clkctl_reg;
        if (wr && hit_clkctl)
        begin
            clkctl_next = pwdata[7:0];
        end
    end

    // flag update: clear first, set wins over read and stop clears
    always_comb
    begin
        status2_next = status2_reg & ~read_clear;
        // general call: stop on bus clears, read does not
        if (bus_event.stop_cond)
        begin
            status2_next[`ST_GCALL_BIT] = 1'b0;
        end
        status2_next = status2_next | flag_set;
        // disabled interface holds all flags clear
        if (!interface_enable)
        begin
            status2_next = `STATUS2_RESET;
        end
    end

    // master indication
    always_comb
    begin
        master_next = master_reg;
        if (bus_event.start_issued)
        begin
            master_next = 1'b1;
        end
        // lost arbitration or stop returns to slave
        if (arb_lost_ev || bus_event.stop_cond)
        begin
            master_next = 1'b0;
        end
        if (!interface_enable)
        begin
            master_next = 1'b0;
        end
    end

    // bus clock generator and stretching
    always_comb
    begin
        scl_state_next = scl_state_reg;
        scl_cnt_next = scl_cnt_reg;
        scl_oe_next = scl_oe_reg;
        unique case (scl_state_reg)
            SCL_IDLE:
            begin
                // line released unless engine flags stretch it or master mode starts the low half
                scl_oe_next = 1'b0;
                scl_cnt_next = 16'h0000;
                if (interface_enable && master_reg && !bus_context.byte_done)
                begin
                    scl_state_next = SCL_LOW;
                    scl_oe_next = 1'b1;
                end
            end
            SCL_HIGH:
            begin
                scl_oe_next = 1'b0;
                // count only once the line really is high
                if (scl_in)
                begin
                    scl_cnt_next = scl_cnt_reg + 16'h0001;
                end
                if (scl_in && (scl_cnt_next >= half_cycles(fast_mode_select, clock_divider)))
                begin
                    scl_cnt_next = 16'h0000;
                    scl_state_next = SCL_LOW;
                    scl_oe_next = 1'b1;
                end
            end
            SCL_LOW:
            begin
                scl_oe_next = 1'b1;
                // fast mode low half is twice the high half
                scl_cnt_next = scl_cnt_reg + 16'h0001;
                if (bus_context.byte_done)
                begin
                    scl_cnt_next = 16'h0000;
                end
                else if (scl_cnt_next >= (fast_mode_select ?
                    16'(half_cycles(1'b1, clock_divider) << 1) :
                    half_cycles(1'b0, clock_divider)))
                begin
                    scl_cnt_next = 16'h0000;
                    scl_state_next = SCL_HIGH;
                    scl_oe_next = 1'b0;
                end
            end
            default:
            begin
                scl_state_next = SCL_IDLE;
                scl_cnt_next = 16'h0000;
                scl_oe_next = 1'b0;
            end
        endcase
        // leaving master or disabling stops the generator
        if (!interface_enable || !master_next)
        begin
            scl_state_next = SCL_IDLE;
            scl_oe_next = 1'b0;
        end
        // stretch from engine flags only, never from error flags
        if (interface_enable && (bus_context.byte_done || bus_context.start_sent))
        begin
            scl_oe_next = 1'b1;
        end
    end

    // control and flag registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= `CTRL_RESET;
            clkctl_reg <= `CLKCTL_RESET;
            status2_reg <= `STATUS2_RESET;
            master_reg <= 1'b0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            clkctl_reg <= clkctl_next;
            status2_reg <= status2_next;
            master_reg <= master_next;
        end
    end

    // apb answer: pready one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= psel & penable & ~pready_reg;
            if (psel && penable && !pready_reg)
            begin
                prdata_reg <= pwrite ? 32'h00000000 : rd_value;
                pslverr_reg <= ~hit_any;
            end
            else if (setup_seen)
            begin
                pslverr_reg <= 1'b0;
            end
        end
    end

    // interrupt request from the four event flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= ctrl_next[`CTRL_IRQ_EN_BIT]
                & (|(status2_next & `ST_READ_CLEAR_MASK));
        end
    end

    // bus clock generator registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scl_state_reg <= SCL_IDLE;
            scl_cnt_reg <= 16'h0000;
            scl_oe_reg <= 1'b0;
        end
        else
        begin
            scl_state_reg <= scl_state_next;
            scl_cnt_reg <= scl_cnt_next;
            scl_oe_reg <= scl_oe_next;
        end
    end

    // outputs straight from flip-flops, except scl_out tied low
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign scl_out = 1'b0;
    assign scl_oe = scl_oe_reg;
    assign master_mode_flag = master_reg;
    assign fast_mode_select = clkctl_reg[`CLK_FAST_BIT];
    assign irq = irq_reg;

endmodule

// ===== logic/twi_flags_regs.svh
`ifndef TWI_FLAGS_REGS_SVH
`define TWI_FLAGS_REGS_SVH

// register byte offsets on the apb bus
`define OFS_CTRL 8'h00
`define OFS_STATUS2 8'h04
`define OFS_CLKCTL 8'h08
`define OFS_STATE 8'h0c

// control register fields
`define CTRL_IRQ_EN_BIT 0
`define CTRL_GC_EN_BIT 4
`define CTRL_IF_EN_BIT 5
`define CTRL_MASK 8'h31

// error status register fields
`define ST_ACK_FAIL_BIT 4
`define ST_STOP_BIT 3
`define ST_ARB_BIT 2
`define ST_FAULT_BIT 1
`define ST_GCALL_BIT 0
`define ST_READ_CLEAR_MASK 5'h1e

// clock control register fields
`define CLK_FAST_BIT 7

// reset values
`define CTRL_RESET 8'h00
`define STATUS2_RESET 5'h00
`define CLKCTL_RESET 8'h00

// bus clock half period: base plus divider times step, in pclk cycles
`define SCL_STD_BASE 16'd20
`define SCL_STD_STEP 16'd4
`define SCL_FAST_BASE 16'd6
`define SCL_FAST_STEP 16'd1

`endif

// ===== logic/twi_flags_pkg.sv
package twi_flags_pkg;

    // per-cycle event pulses from the byte transfer engine
    typedef struct packed {
        logic nack;          // transmitted byte not acknowledged
        logic stop_cond;     // stop condition seen on the bus
        logic arb_lost;      // another master won arbitration
        logic misplaced;     // start or stop at a wrong position
        logic gc_addr;       // general call address received
        logic start_issued;  // start condition generated (enter master)
    } bus_event_t;

    // engine context levels qualifying the events
    typedef struct packed {
        logic ack_enable;    // acknowledge enabled
        logic acked_last;    // last byte was acknowledged
        logic rx_ack_phase;  // master receiver in its own ack bit
        logic start_sent;    // start-sent flag of first status register
        logic byte_done;     // byte-transfer-finished flag
    } bus_context_t;

    // bus clock generator states, one-hot
    typedef enum logic [2:0] {
        SCL_IDLE = 3'b001,
        SCL_HIGH = 3'b010,
        SCL_LOW = 3'b100
    } scl_state_t;

endpackage

// ===== test/twi_flags_monitor.sv
`timescale 1ns/10ps
module twi_flags_monitor
    import twi_flags_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // apb side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // engine and line side
    input wire bus_event_t bus_event,
    input wire bus_context_t bus_context,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic master_mode_flag,
    input wire logic fast_mode_select,
    input wire logic irq
);
    logic [7:0] ctrl_reg; // shadow of control register
    wire done = pready && psel && penable;
    wire ctrl_wr = done && pwrite && paddr == 8'h00;
    wire clk_wr = done && pwrite && paddr == 8'h08;
    wire en = ctrl_reg[5];
    wire quiet = !bus_context.byte_done && !bus_context.start_sent;
    // shadow follows completed writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_reg <= 8'h00;
        else if (ctrl_wr)
            ctrl_reg <= pwdata[7:0];
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_access_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("apb answer not after one wait state");
    a_rsvd_zero: assert property (done && !pwrite && paddr == 8'h04 |-> prdata[31:5] == 27'h0)
        else $error("reserved status bits not zero");
    a_irq_raise: assert property (en && ctrl_reg[0] && bus_event.nack |=> irq)
        else $error("irq missing after ack fail");
    a_irq_masked: assert property (!ctrl_reg[0] && $past(!ctrl_reg[0]) |-> !irq)
        else $error("irq while disabled");
    a_off_clears: assert property (!en && $past(!en) |-> !irq)
        else $error("flags alive while interface off");
    a_no_err_stretch: assert property (en && !master_mode_flag && quiet
        && !bus_event.start_issued |=> !scl_oe)
        else $error("clock line held by error flags");
    a_done_holds: assert property (en && bus_context.byte_done |=> scl_oe)
        else $error("clock line not held on byte done");
    a_arb_to_slave: assert property (en && bus_event.arb_lost && !bus_context.rx_ack_phase
        && !bus_event.start_issued |=> !master_mode_flag)
        else $error("still master after lost arbitration");
    a_fast_select: assert property (clk_wr |=> fast_mode_select == $past(pwdata[7]))
        else $error("fast select not taken from write");
endmodule

// ===== test/twi_bus_peer.sv
`timescale 1ns/10ps
module twi_bus_peer
    import twi_flags_pkg::*;
(
    // clock and block drive
    input wire logic pclk,
    input wire logic scl_oe,
    // line and engine view
    output logic scl_in,
    output bus_event_t ev,
    output bus_context_t ctx
);
    logic hold_low = 1'b0; // peer stretching the line
    bus_event_t ev_drv = '0; // engine event pulses
    bus_context_t ctx_drv = '0; // engine context levels
    // pull-up: high unless someone pulls low
    assign scl_in = !(scl_oe || hold_low);
    assign ev = ev_drv;
    assign ctx = ctx_drv;
    // one-cycle event pulse, then a quiet cycle
    task automatic fire(input bus_event_t e);
        ev_drv <= e;
        @(posedge pclk);
        ev_drv <= '0;
        @(posedge pclk);
    endtask
    // engine context levels, changed just after an edge
    task automatic set_ctx(input bus_context_t c);
        ctx_drv <= c;
    endtask
    // grab or let go of the clock line
    task automatic hold(input logic v);
        hold_low <= v;
    endtask
endmodule

// ===== test/testbench.sv
`timescale 1ns/10ps
`include "twi_flags_regs.svh"
module testbench;
    import twi_flags_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, scl_in, scl_out, scl_oe;
    logic master_mode_flag, fast_mode_select, irq;
    bus_event_t bus_event;
    bus_context_t bus_context;
    bus_event_t evs[3] = '{6'h20, 6'h08, 6'h04}; // ack fail, arb lost, fault
    logic [31:0] bits[3] = '{32'h10, 32'h04, 32'h02};
    int error_cnt = 0;
    int samples_checked = 0;
    int n; // measured clock phase length in cycles
    twi_flags #(.ADDR_W(8)) i_dut(.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_event(bus_event),
        .bus_context(bus_context), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
        .master_mode_flag(master_mode_flag), .fast_mode_select(fast_mode_select), .irq(irq));
    twi_bus_peer i_peer(.pclk(pclk), .scl_oe(scl_oe), .scl_in(scl_in),
        .ev(bus_event), .ctx(bus_context));
    initial
    begin
        forever #5 pclk = ~pclk;
    end
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // verdict and end of run
    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #200us;
        error_cnt++;
        report_and_stop;
    end
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(8'h04, 32'h0);
        rdchk(8'h08, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 8'h08, 32'h85);
        apb(1'b1, 8'h00, 32'h31);
        // each error event sets its own bit, read clears it
        foreach (evs[i])
        begin
            i_peer.fire(evs[i]);
            chk({31'h0, irq}, 32'h1);
            chk({31'h0, scl_oe}, 32'h0);
            rdchk(8'h04, bits[i] | 32'h0);
            rdchk(8'h04, 32'h0);
        end
        // fault then stop without ack context: stop flag refused
        i_peer.fire(6'h04);
        i_peer.fire(6'h10);
        rdchk(8'h04, 32'h02);
        // general call survives reads until stop after ack
        i_peer.set_ctx(5'b11000);
        i_peer.fire(6'h02);
        rdchk(8'h04, 32'h01);
        rdchk(8'h04, 32'h01);
        i_peer.fire(6'h10);
        rdchk(8'h04, 32'h08);
        // arbitration ignored in own ack bit, lost otherwise
        i_peer.fire(6'h01);
        i_peer.set_ctx(5'b00100);
        i_peer.fire(6'h08);
        chk({31'h0, master_mode_flag}, 32'h1);
        rdchk(8'h04, 32'h0);
        i_peer.set_ctx(5'b00000);
        i_peer.fire(6'h08);
        chk({31'h0, master_mode_flag}, 32'h0);
        rdchk(8'h04, 32'h04);
        // masked irq, then disable clears flags, keeps clock setup
        apb(1'b1, 8'h00, 32'h30);
        i_peer.fire(6'h20);
        chk({31'h0, irq}, 32'h0);
        i_peer.fire(6'h02);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h00, 32'h30);
        rdchk(8'h04, 32'h0);
        rdchk(8'h08, 32'h85);
        chk({31'h0, fast_mode_select}, 32'h1);
        // byte done holds the line, clock output stays low
        i_peer.set_ctx(5'b00001);
        repeat (2) @(posedge pclk);
        chk({31'h0, scl_oe}, 32'h1);
        chk({31'h0, scl_out}, 32'h0);
        // start sent also holds the line, peer stretch seen on line
        i_peer.set_ctx(5'b00010);
        repeat (2) @(posedge pclk);
        chk({31'h0, scl_oe}, 32'h1);
        i_peer.set_ctx(5'b00000);
        i_peer.hold(1'b1);
        repeat (2) @(posedge pclk);
        chk({31'h0, scl_oe}, 32'h0);
        rdchk(8'h0c, 32'h0);
        i_peer.hold(1'b0);
        rdchk(8'h0c, 32'h4);
        // generator, fast mode, divider 5: low twice the half, high one half
        i_peer.fire(6'h01);
        while (scl_oe !== 1'b1)
        begin
            @(posedge pclk);
        end
        n = 0;
        while (scl_oe === 1'b1)
        begin
            n++;
            @(posedge pclk);
        end
        chk(n, 2 * (`SCL_FAST_BASE + 5 * `SCL_FAST_STEP));
        n = 0;
        while (scl_oe === 1'b0)
        begin
            n++;
            @(posedge pclk);
        end
        chk(n, `SCL_FAST_BASE + 5 * `SCL_FAST_STEP);
        i_peer.fire(6'h10);
        chk({31'h0, scl_oe}, 32'h0);
        report_and_stop;
    end
endmodule
bind twi_flags twi_flags_monitor #(.ADDR_W(ADDR_W)) i_mon(.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_event(bus_event),
    .bus_context(bus_context), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .master_mode_flag(master_mode_flag), .fast_mode_select(fast_mode_select), .irq(irq));
